/* hdl/sfd_store_forward.sv */
// Memory order buffer: store buffer, store-to-load forwarding and load disambiguation.
// Assumes the issue/retire pipeline and L1 data cache run on sys_clk; all inputs are
// synchronous to it, so none is resynchronised.
`timescale 1ns/100ps

// What this block does
// RULE1 - Stores are kept in the buffer and only sent to the cache once they have retired.
// RULE2 - A younger load to the address of a buffered older store may take that store's data.
// RULE3 - If forwarding is not allowed the load waits until the store is in the cache, then reads it; a load held only for data forwards once it arrives.
// RULE4 - Forwarding needs both a size and alignment match and store data that is present.
// RULE5 - Loads may issue ahead of older stores whose addresses are still unknown.
// RULE6 - A resolving store address that overlaps a speculative younger load replays that load.
// RULE7 - A control bit turns off speculative bypass so loads wait for all older store addresses.
// RULE8 - A forwarded load gets its value from the buffer and makes no cache read.
// RULE9 - Forwarding a floating-point store value takes more cycles than an integer one.
// RULE10 - With several matching older stores the youngest of them supplies the data.
module sfd_store_forward
	import sfd_pkg::*;
#(
	parameter int N = SFD_STB_DEPTH,
	parameter int M = SFD_LDQ_DEPTH,
	parameter int AW = SFD_ADDR_W,
	parameter int DW = SFD_DATA_W
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control bit from the speculation control register
	input wire logic speculativeBypassDisable,
	// Store allocation, address and data resolution, retirement
	input wire logic stAllocValid,
	input wire logic stAllocFp,
	output logic stAllocReady,
	output logic [$clog2(N):0] stTailSeq,
	input wire logic stAddrValid,
	input wire logic [$clog2(N)-1:0] stAddrIdx,
	input wire logic [AW-1:0] stAddr,
	input wire logic [SFD_SIZE_W-1:0] stSize,
	input wire logic stDataValid,
	input wire logic [$clog2(N)-1:0] stDataIdx,
	input wire logic [DW-1:0] stData,
	input wire logic stRetire,
	// Cache write port for retired stores
	output logic cacheWrValid,
	output logic [AW-1:0] cacheWrAddr,
	output logic [SFD_SIZE_W-1:0] cacheWrSize,
	output logic [DW-1:0] cacheWrData,
	input wire logic cacheWrReady,
	// Load request
	input wire logic ldValid,
	input wire logic [$clog2(M)-1:0] ldId,
	input wire logic [AW-1:0] ldAddr,
	input wire logic [SFD_SIZE_W-1:0] ldSize,
	input wire logic [$clog2(N):0] ldTail,
	output logic ldReady,
	input wire logic ldCommitValid,
	input wire logic [$clog2(M)-1:0] ldCommitId,
	// Load answers: forwarded data, cache read request, replay
	output logic ldFwdValid,
	output logic [$clog2(M)-1:0] ldFwdId,
	output logic [DW-1:0] ldFwdData,
	output logic ldCacheValid,
	output logic [$clog2(M)-1:0] ldCacheId,
	output logic [AW-1:0] ldCacheAddr,
	output logic [SFD_SIZE_W-1:0] ldCacheSize,
	output logic replayValid,
	output logic [$clog2(M)-1:0] replayId
);

	localparam int IW = $clog2(N);
	localparam int PW = IW + 1;
	localparam int LW = $clog2(M);
	localparam int SW = SFD_SIZE_W;
	localparam int GL = SFD_GRAN_LSB;
	localparam int FpFwdLat = SFD_FP_FWD_EXTRA + 1;

	typedef struct packed {
		sfd_state_e state;
		logic [PW-1:0] head;
		logic [PW-1:0] tail;
		logic [PW-1:0] retPtr;
		logic [N-1:0] stV;
		logic [N-1:0] stAk;
		logic [N-1:0] stDk;
		logic [N-1:0] stFp;
		logic [N-1:0][AW-1:0] stA;
		logic [N-1:0][SW-1:0] stSz;
		logic [N-1:0][DW-1:0] stD;
		logic [M-1:0] spV;
		logic [M-1:0][AW-1:0] spA;
		logic [M-1:0][PW-1:0] spT;
		logic [LW-1:0] hId;
		logic [AW-1:0] hA;
		logic [SW-1:0] hSz;
		logic [PW-1:0] hT;
		logic [SFD_FP_CNT_W-1:0] fpCnt;
		logic ldRdy;
		logic allocRdy;
		logic fwdV;
		logic [LW-1:0] fwdId;
		logic [DW-1:0] fwdD;
		logic cV;
		logic [LW-1:0] cId;
		logic [AW-1:0] cA;
		logic [SW-1:0] cSz;
		logic wV;
		logic [AW-1:0] wA;
		logic [SW-1:0] wSz;
		logic [DW-1:0] wD;
		logic rpV;
		logic [LW-1:0] rpId;
	} sfd_regs_s;

	sfd_regs_s s_r;
	sfd_regs_s s_nxt;

	logic take;
	logic evalLd;
	logic [LW-1:0] curId;
	logic [AW-1:0] curA;
	logic [SW-1:0] curSz;
	logic [PW-1:0] curT;
	logic unknownOlder;
	logic candFound;
	logic [IW-1:0] candIdx;
	logic fwdOk;
	logic raceHit;
	logic [M-1:0] specHit;
	logic [LW-1:0] specOldest;
	logic [IW-1:0] hIdx;

	// The load under evaluation is a new request or the one held while blocked
	assign take = ldValid && s_r.ldRdy;
	assign evalLd = take || (s_r.state == SFD_BLOCK);
	assign curId = take ? ldId : s_r.hId;
	assign curA = take ? ldAddr : s_r.hA;
	assign curSz = take ? ldSize : s_r.hSz;
	assign curT = take ? ldTail : s_r.hT;
	assign hIdx = s_r.head[IW-1:0];

	// Scan older stores oldest first, so the last match is the youngest older one
	always_comb
	begin
		logic [PW-1:0] dT;
		logic [IW-1:0] ix;
		dT = curT - s_r.head;
		ix = '0;
		unknownOlder = 1'b0;
		candFound = 1'b0;
		candIdx = '0;
		for (int k = 0; k < N; k++)
		begin
			ix = hIdx + IW'(k);
			if (PW'(k) < dT && s_r.stV[ix])
			begin
				if (!s_r.stAk[ix])
					unknownOlder = 1'b1;
				else if (s_r.stA[ix][AW-1:GL] == curA[AW-1:GL])
				begin
					candFound = 1'b1;
					candIdx = ix; // [RULE10]
				end
			end
		end
		// Same start address, load inside the store, data present
		fwdOk = (s_r.stA[candIdx] == curA) && (curSz <= s_r.stSz[candIdx])
			&& s_r.stDk[candIdx]; // [RULE4]
	end

	// Check a resolving store address against loads that ran past it
	always_comb
	begin
		logic [PW-1:0] dRes;
		logic [PW-1:0] best;
		dRes = {1'b0, stAddrIdx - hIdx};
		specOldest = '0;
		best = '1;
		for (int j = 0; j < M; j++)
		begin
			specHit[j] = stAddrValid && s_r.spV[j] && (dRes < (s_r.spT[j] - s_r.head))
				&& (s_r.spA[j][AW-1:GL] == stAddr[AW-1:GL]); // [RULE6]
			if (specHit[j] && (s_r.spT[j] - s_r.head) < best)
			begin
				best = s_r.spT[j] - s_r.head;
				specOldest = LW'(j);
			end
		end
		// A store resolving in the very cycle the load is judged is caught here
		raceHit = stAddrValid && (dRes < (curT - s_r.head))
			&& (stAddr[AW-1:GL] == curA[AW-1:GL]);
	end

	// Next state of the whole block
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.fwdV = 1'b0;
		s_nxt.cV = 1'b0;
		s_nxt.rpV = 1'b0;
		// Store buffer bookkeeping
		if (stAllocValid && s_r.allocRdy)
		begin
			s_nxt.stV[s_r.tail[IW-1:0]] = 1'b1;
			s_nxt.stAk[s_r.tail[IW-1:0]] = 1'b0;
			s_nxt.stDk[s_r.tail[IW-1:0]] = 1'b0;
			s_nxt.stFp[s_r.tail[IW-1:0]] = stAllocFp;
			s_nxt.tail = s_r.tail + PW'(1);
		end
		if (stAddrValid)
		begin
			s_nxt.stAk[stAddrIdx] = 1'b1;
			s_nxt.stA[stAddrIdx] = stAddr;
			s_nxt.stSz[stAddrIdx] = stSize;
		end
		if (stDataValid)
		begin
			s_nxt.stDk[stDataIdx] = 1'b1;
			s_nxt.stD[stDataIdx] = stData;
		end
		if (stRetire)
			s_nxt.retPtr = s_r.retPtr + PW'(1);
		// Drain only retired stores; the entry stays forwardable until the cache takes it
		if (s_r.wV && cacheWrReady)
		begin
			s_nxt.stV[hIdx] = 1'b0;
			s_nxt.head = s_r.head + PW'(1);
			s_nxt.wV = 1'b0;
		end
		else if (!s_r.wV && s_r.stV[hIdx] && (s_r.head != s_r.retPtr)
			&& s_r.stAk[hIdx] && s_r.stDk[hIdx]) // [RULE1]
		begin
			s_nxt.wV = 1'b1;
			s_nxt.wA = s_r.stA[hIdx];
			s_nxt.wSz = s_r.stSz[hIdx];
			s_nxt.wD = s_r.stD[hIdx];
		end
		s_nxt.allocRdy = (s_nxt.tail - s_nxt.head) != PW'(N);
		// Speculative load tracking: commit frees, a late overlap replays
		if (ldCommitValid)
			s_nxt.spV[ldCommitId] = 1'b0;
		if (|specHit)
		begin
			s_nxt.rpV = 1'b1; // [RULE6]
			s_nxt.rpId = specOldest;
			s_nxt.spV = s_nxt.spV & ~specHit;
		end
		// Load sequencing
		if (evalLd)
		begin
			s_nxt.hId = curId;
			s_nxt.hA = curA;
			s_nxt.hSz = curSz;
			s_nxt.hT = curT;
			if ((speculativeBypassDisable && unknownOlder) // [RULE7]
				|| (candFound && !fwdOk) || raceHit) // [RULE3]
				s_nxt.state = SFD_BLOCK;
			else
			begin
				s_nxt.state = SFD_IDLE;
				s_nxt.fwdId = curId;
				s_nxt.fwdD = s_r.stD[candIdx];
				if (candFound && s_r.stFp[candIdx])
				begin
					// Slower path for floating-point data
					s_nxt.state = SFD_FPWAIT; // [RULE9]
					s_nxt.fpCnt = SFD_FP_CNT_W'(SFD_FP_FWD_EXTRA);
				end
				else if (candFound)
					s_nxt.fwdV = 1'b1; // [RULE2] [RULE8]
				else
				begin
					s_nxt.cV = 1'b1;
					s_nxt.cId = curId;
					s_nxt.cA = curA;
					s_nxt.cSz = curSz;
				end
				if (unknownOlder)
				begin
					// Issued past unknown stores: remember for the later check
					s_nxt.spV[curId] = 1'b1; // [RULE5]
					s_nxt.spA[curId] = curA;
					s_nxt.spT[curId] = curT;
				end
			end
		end
		else if (s_r.state == SFD_FPWAIT)
		begin
			s_nxt.fpCnt = s_r.fpCnt - SFD_FP_CNT_W'(1);
			if (s_r.fpCnt == SFD_FP_CNT_W'(1))
			begin
				s_nxt.fwdV = 1'b1;
				s_nxt.state = SFD_IDLE;
			end
		end
		s_nxt.ldRdy = (s_nxt.state == SFD_IDLE);
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.state <= SFD_IDLE;
			s_r.ldRdy <= 1'b1;
			s_r.allocRdy <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs straight from the state register
	assign stAllocReady = s_r.allocRdy;
	assign stTailSeq = s_r.tail;
	assign cacheWrValid = s_r.wV;
	assign cacheWrAddr = s_r.wA;
	assign cacheWrSize = s_r.wSz;
	assign cacheWrData = s_r.wD;
	assign ldReady = s_r.ldRdy;
	assign ldFwdValid = s_r.fwdV;
	assign ldFwdId = s_r.fwdId;
	assign ldFwdData = s_r.fwdD;
	assign ldCacheValid = s_r.cV;
	assign ldCacheId = s_r.cId;
	assign ldCacheAddr = s_r.cA;
	assign ldCacheSize = s_r.cSz;
	assign replayValid = s_r.rpV;
	assign replayId = s_r.rpId;

	// Checks beside the logic they guard
	retired_drain_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
		$rose(cacheWrValid) |-> $past(s_r.head != s_r.retPtr))
		else $error("store sent to cache before retirement");
	drain_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
		cacheWrValid && !cacheWrReady |=> cacheWrValid && $stable(cacheWrAddr))
		else $error("cache write dropped before acceptance");
	int_forward_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
		evalLd && candFound && fwdOk && !raceHit && !s_r.stFp[candIdx]
		&& !(speculativeBypassDisable && unknownOlder)
		|=> ldFwdValid && ldFwdId == $past(curId) && !ldCacheValid)
		else $error("integer forward not delivered next cycle");
	no_cache_fwd_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
		ldFwdValid |-> !ldCacheValid)
		else $error("forwarded load also read the cache");
	blocked_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
		evalLd && candFound && !fwdOk |=> !ldFwdValid && !ldCacheValid && !ldReady)
		else $error("load not held on failed forward");
	fp_latency_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
		s_r.state == SFD_IDLE && s_nxt.state == SFD_FPWAIT
		|-> ##FpFwdLat ldFwdValid)
		else $error("floating-point forward latency wrong");
	bypass_off_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
		evalLd && speculativeBypassDisable && unknownOlder
		|=> s_r.state == SFD_BLOCK && !ldCacheValid && !ldFwdValid)
		else $error("load bypassed unknown store while disabled");
	spec_issue_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE5]
		evalLd && !speculativeBypassDisable && unknownOlder && !candFound && !raceHit
		|=> ldCacheValid && s_r.spV[ldCacheId])
		else $error("speculative load not issued or not tracked");
	replay_hit_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
		|specHit |=> replayValid && !s_r.spV[replayId])
		else $error("overlapping speculative load not replayed");

endmodule : sfd_store_forward

/* hdl/sfd_pkg.sv */
// Shared constants and types of the store forwarding and disambiguation block.
// Assumes a single core clock domain; all users import the whole package.
package sfd_pkg;

	// Datapath widths and buffer depths
	localparam int SFD_ADDR_W = 32;
	localparam int SFD_DATA_W = 64;
	localparam int SFD_SIZE_W = 2;          // Access size as log2 of bytes
	localparam int SFD_STB_DEPTH = 8;       // Store buffer entries
	localparam int SFD_LDQ_DEPTH = 4;       // Tracked speculative loads

	// Overlap is judged per naturally aligned 8-byte granule
	localparam int SFD_GRAN_LSB = 3;

	// Extra cycles spent forwarding a floating-point store value
	localparam int SFD_FP_FWD_EXTRA = 4;
	localparam int SFD_FP_CNT_W = 3;

	// Load sequencer states
	typedef enum logic [2:0]
	{
		SFD_IDLE = 3'h1,
		SFD_FPWAIT = 3'h2,
		SFD_BLOCK = 3'h4
	} sfd_state_e;

endpackage : sfd_pkg

/* sim/sfd_cache_model.sv */
// Behavioural L1 data cache write port facing the store buffer.
// Assumes the core clock and reset; stall is driven by the bench.
`timescale 1ns/100ps
module sfd_cache_model
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Write port
	input wire logic cacheWrValid,
	input wire logic [SFD_DATA_W-1:0] cacheWrData,
	output logic cacheWrReady,
	// Bench control and observation
	input wire logic stall,
	output int wrCount,
	output logic [SFD_DATA_W-1:0] lastData
);
	// A stalled cache refuses writes, so the buffer must hold them
	assign cacheWrReady = !stall;
	// Count and keep each accepted write
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			wrCount <= 0;
			lastData <= '0;
		end
		else if (cacheWrValid && cacheWrReady)
		begin
			wrCount <= wrCount + 1;
			lastData <= cacheWrData;
		end
endmodule : sfd_cache_model

/* sim/test_sfd_store_forward.sv */
// Self-checking bench of the store forwarding block with a cache model.
// Assumes one 50 MHz core clock for the design and the model.
`timescale 1ns/100ps
module test_sfd_store_forward
	import sfd_pkg::*;
;
	logic sys_clk, rst, byp, alV, alFp, alR, adV, daV, ret, wrV, wrR, ldV, ldR, cmV;
	logic fwV, caV, rpV, stall;
	logic [3:0] tail, ldTl;
	logic [2:0] adI, daI, i0, i1;
	logic [1:0] adS, ldS, id, fwI, caI, rpI, wrS, caS;
	logic [31:0] adA, ldA, caA, wrA, seed, a, b;
	logic [63:0] daD, wrD, fwD, lastD, d0, d1;
	int wrCnt, nMismatch, checked, cyc, k;

	sfd_store_forward u_sfd_store_forward (.sys_clk(sys_clk), .rst(rst),
		.speculativeBypassDisable(byp), .stAllocValid(alV), .stAllocFp(alFp),
		.stAllocReady(alR), .stTailSeq(tail), .stAddrValid(adV), .stAddrIdx(adI),
		.stAddr(adA), .stSize(adS), .stDataValid(daV), .stDataIdx(daI), .stData(daD),
		.stRetire(ret), .cacheWrValid(wrV), .cacheWrAddr(wrA), .cacheWrSize(wrS),
		.cacheWrData(wrD), .cacheWrReady(wrR), .ldValid(ldV), .ldId(id), .ldAddr(ldA),
		.ldSize(ldS), .ldTail(ldTl), .ldReady(ldR), .ldCommitValid(cmV),
		.ldCommitId(id), .ldFwdValid(fwV), .ldFwdId(fwI), .ldFwdData(fwD),
		.ldCacheValid(caV), .ldCacheId(caI), .ldCacheAddr(caA), .ldCacheSize(caS),
		.replayValid(rpV), .replayId(rpI));
	sfd_cache_model u_sfd_cache_model (.sys_clk(sys_clk), .rst(rst),
		.cacheWrValid(wrV), .cacheWrData(wrD), .cacheWrReady(wrR), .stall(stall),
		.wrCount(wrCnt), .lastData(lastD));

	// Clock, and a ceiling well above the hundred or so cycles the tests need
	initial
	begin
		sys_clk = 0;
		forever #10 sys_clk = !sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			nMismatch++;
			give_verdict();
		end
	end

	// Inputs move 1 ns after the edge so sampling never races
	task tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Answer delay promised for a forward, counted from the taking edge
	function int fwd_lat(input logic fp);
		return fp ? 1 + SFD_FP_FWD_EXTRA : 1;
	endfunction : fwd_lat
	task chk(input bit ok, input string m);
		checked++;
		if (!ok)
		begin
			nMismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task alloc(input logic fp, output logic [2:0] ix);
		ix = tail[2:0];
		alV = 1;
		alFp = fp;
		tick();
		alV = 0;
	endtask : alloc
	task sAddr(input logic [2:0] i, input logic [31:0] ad, input logic [1:0] s);
		adV = 1;
		adI = i;
		adA = ad;
		adS = s;
		tick();
		adV = 0;
	endtask : sAddr
	task sData(input logic [2:0] i, input logic [63:0] d);
		daV = 1;
		daI = i;
		daD = d;
		tick();
		daV = 0;
	endtask : sData
	// Retire n stores with the cache stalled, then let them drain
	task retDrain(input int n, input logic [31:0] ea, input logic [1:0] es);
		int t;
		t = wrCnt + n;
		stall = 1;
		repeat (n)
		begin
			ret = 1;
			tick();
		end
		ret = 0;
		repeat (4) tick();
		chk(wrCnt == t - n && wrV === 1'b1 && wrA === ea && wrS === es, "write not held");
		stall = 0;
		k = 0;
		while (wrCnt != t && k < 50)
		begin
			tick();
			k++;
		end
		chk(wrCnt == t, "drain");
	endtask : retDrain
	task load(input logic [31:0] ad, input logic [1:0] s);
		id = id + 2'h1;
		ldV = 1;
		ldA = ad;
		ldS = s;
		ldTl = tail;
		tick();
		ldV = 0;
	endtask : load
	// Cycles from the taking edge until an answer shows
	task await(input int lim);
		k = 1;
		while (!(fwV === 1'b1 || caV === 1'b1) && k < lim)
		begin
			tick();
			k++;
		end
	endtask : await
	task commit;
		cmV = 1;
		tick();
		cmV = 0;
	endtask : commit
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	initial
	begin
		{byp, alV, alFp, adV, daV, ret, ldV, cmV, stall, adI, daI, adS, ldS, id} = '0;
		{adA, ldA, daD, ldTl} = '0;
		rst = 1;
		seed = 32'h5b630aae;
		repeat (5) @(posedge sys_clk);
		#1 rst = 0;
		chk(ldR === 1'b1 && alR === 1'b1 && tail === 4'h0 && wrV === 1'b0, "reset");
		// Two matching stores: the younger forwards, nothing reaches the cache yet
		a = rnd() & 32'hfffffff8;
		d0 = {rnd(), rnd()};
		d1 = {rnd(), rnd()};
		alloc(1'b0, i0);
		tick();
		alloc(1'b0, i1);
		sAddr(i0, a, 2'h3);
		tick();
		sAddr(i1, a, 2'h3);
		sData(i0, d0);
		tick();
		sData(i1, d1);
		load(a, 2'h3);
		await(10);
		chk(fwV === 1'b1 && k == fwd_lat(1'b0) && caV === 1'b0, "int forward");
		chk(fwD === d1 && fwI === id, "youngest data");
		chk(wrCnt == 0, "early write");
		commit();
		retDrain(2, a, 2'h3);
		chk(lastD === d1, "write order");
		$display("test forward done");
		// Floating-point store forwards later
		alloc(1'b1, i0);
		sAddr(i0, a, 2'h3);
		sData(i0, d0);
		load(a, 2'h3);
		await(20);
		chk(fwV === 1'b1 && k == fwd_lat(1'b1) && fwD === d0, "fp forward");
		commit();
		retDrain(1, a, 2'h3);
		$display("test fp done");
		// Load wider than the store: blocked until the store is in the cache
		alloc(1'b0, i0);
		sAddr(i0, a, 2'h1);
		sData(i0, d1);
		load(a, 2'h3);
		repeat (3) tick();
		chk(ldR === 1'b0 && fwV === 1'b0 && caV === 1'b0, "not blocked");
		retDrain(1, a, 2'h1);
		await(20);
		chk(caV === 1'b1 && caA === a && caI === id && caS === 2'h3, "cache read");
		commit();
		$display("test size done");
		// Load passes an unknown store, then the store overlaps it
		b = rnd() & 32'hfffffff8;
		alloc(1'b0, i0);
		load(b, 2'h3);
		await(10);
		chk(caV === 1'b1 && k == 1 && caA === b && caS === 2'h3, "speculative load");
		sAddr(i0, b | 32'h4, 2'h2);
		chk(rpV === 1'b1 && rpI === id, "replay");
		commit();
		sData(i0, d0);
		retDrain(1, b | 32'h4, 2'h2);
		$display("test replay done");
		// Address resolves in the cycle the load is taken; data arrives later
		alloc(1'b0, i0);
		id = id + 2'h1;
		{adV, adI, adA, adS} = {1'b1, i0, b, 2'h3};
		{ldV, ldA, ldS, ldTl} = {1'b1, b, 2'h3, tail};
		tick();
		{adV, ldV} = '0;
		repeat (2) tick();
		chk(ldR === 1'b0 && fwV === 1'b0 && caV === 1'b0, "race not held");
		sData(i0, d1);
		await(10);
		chk(fwV === 1'b1 && fwD === d1 && fwI === id, "forward after data");
		commit();
		retDrain(1, b, 2'h3);
		$display("test race done");
		// Bypass disabled: load waits for the older store address
		byp = 1;
		alloc(1'b0, i0);
		load(b, 2'h3);
		repeat (3) tick();
		chk(ldR === 1'b0 && caV === 1'b0 && fwV === 1'b0, "bypassed");
		sAddr(i0, b ^ 32'h100, 2'h3);
		await(10);
		chk(caV === 1'b1 && caA === b, "late load");
		byp = 0;
		commit();
		sData(i0, d1);
		retDrain(1, b ^ 32'h100, 2'h3);
		$display("test disable done");
		give_verdict();
	end
endmodule : test_sfd_store_forward
